/* File: core/event_flag_regs.v */
`include "cycle_timer_defines.vh"

module event_flag_regs (
  // Clock and reset
  input  wire        clk,
  input  wire        srst,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire        hready,
  input  wire [31:0] hwdata,
  output wire [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  // Receiver events
  input  wire        rx_hdr_crc_err,
  input  wire        rx_cycle_start_rcvd,
  // Transmitter events
  input  wire        tx_bad_tcode,
  input  wire        tx_cycle_start_sent,
  input  wire        cycle_start_arb_lost,
  input  wire        iso_arb_lost,
  // Bus gap detector
  input  wire        arb_gap_seen,
  // External cycle source pin
  input  wire        ext_cycle_pin,
  // Isochronous receive filter
  input  wire        rx_iso_hdr_valid,
  input  wire [5:0]  rx_iso_channel,
  output wire        rx_iso_accept,
  // Cycle control to the transmitter
  output wire        cycle_start_req,
  output wire        cycle_pending,
  output wire [31:0] cycle_time,
  // Interrupt
  output wire        irq
);

  // ----------------------------------------
  // Bus slave state
  // ----------------------------------------
  reg  [31:0] hrdata_q;
  reg         hreadyout_q;
  reg         hresp_q;
  reg         wr_pend_q;
  reg  [11:0] wr_addr_q;

  wire        addr_phase = hsel && htrans[1] && hready;
  wire [11:0] word_addr  = {haddr[11:2], 2'b00};

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  reg  [31:0] ctrl_q;
  reg  [31:0] enable_q;
  reg  [31:0] enable_d;
  reg  [31:0] iso_q;
  reg  [31:0] status_q;
  reg  [31:0] status_d;

  wire wr_ctrl   = wr_pend_q && (wr_addr_q == `OFS_CTRL);
  wire wr_enable = wr_pend_q && (wr_addr_q == `OFS_ENABLE);
  wire wr_timer  = wr_pend_q && (wr_addr_q == `OFS_TIMER);
  wire wr_iso    = wr_pend_q && (wr_addr_q == `OFS_ISO);
  wire wr_clear  = wr_pend_q && (wr_addr_q == `OFS_CLEAR);

  wire timer_en   = ctrl_q[`CTL_TIMER_EN];
  wire cyc_master = ctrl_q[`CTL_CYC_MASTER];
  wire cyc_source = ctrl_q[`CTL_CYC_SOURCE];

  // ----------------------------------------
  // External cycle pin synchroniser
  // ----------------------------------------
  reg  [2:0] pin_sync_q;
  reg        pin_level_q;
  wire       pin_agree = (pin_sync_q[1] == pin_sync_q[2]);
  wire       pin_rise  = pin_agree && pin_sync_q[1] && !pin_level_q;

  always @(posedge clk) begin
    if (srst) begin
      pin_sync_q  <= 3'h0;
      pin_level_q <= 1'b0;
    end else begin
      pin_sync_q <= {pin_sync_q[1:0], ext_cycle_pin};
      if (pin_agree) begin
        pin_level_q <= pin_sync_q[1];
      end
    end
  end

  // ----------------------------------------
  // Cycle timer
  // ----------------------------------------
  wire [31:0] timer_value;
  wire        sec_pulse;
  wire        zero_pulse;
  wire        roll_pulse;

  bus_time_counter u_timer (
    .clk          (clk),
    .srst         (srst),
    .enable       (timer_en),
    .ext_source   (cyc_source),
    .ext_tick     (pin_rise),
    .load         (wr_timer),
    .load_value   (hwdata),
    .value_q      (timer_value),
    .sec_pulse_q  (sec_pulse),
    .zero_pulse_q (zero_pulse),
    .roll_pulse_q (roll_pulse)
  );

  // ----------------------------------------
  // Isochronous channel filter
  // ----------------------------------------
  wire accept_w;

  iso_channel_match u_iso (
    .clk         (clk),
    .srst        (srst),
    .port_enable ({ctrl_q[`CTL_ISO_B_EN], ctrl_q[`CTL_ISO_A_EN]}),
    .chan_a      (iso_q[`ISO_A_CHAN_HI:`ISO_A_CHAN_LO]),
    .chan_b      (iso_q[`ISO_B_CHAN_HI:`ISO_B_CHAN_LO]),
    .hdr_valid   (rx_iso_hdr_valid),
    .hdr_channel (rx_iso_channel),
    .accept_q    (accept_w)
  );

  // ----------------------------------------
  // Isochronous cycle tracking
  // ----------------------------------------
  reg        in_cycle_q;
  reg        pend_q;
  reg  [1:0] miss_cnt_q;
  reg        start_req_q;

  wire cyc_begin = tx_cycle_start_sent || rx_cycle_start_rcvd;
  // A gap only closes a cycle that a start packet actually opened
  wire cyc_done  = arb_gap_seen && in_cycle_q;
  wire miss_step = roll_pulse && !cyc_master && !rx_cycle_start_rcvd;
  wire cyc_lost  = miss_step && (miss_cnt_q == `LOST_ROLLS - 2'd1);

  always @(posedge clk) begin
    if (srst) begin
      in_cycle_q  <= 1'b0;
      pend_q      <= 1'b0;
      miss_cnt_q  <= 2'h0;
      start_req_q <= 1'b0;
    end else begin
      if (cyc_begin) begin
        in_cycle_q <= 1'b1;
      end else if (cyc_done) begin
        in_cycle_q <= 1'b0;
      end
      if (zero_pulse) begin
        pend_q <= 1'b1;
      end else if (cyc_done) begin
        pend_q <= 1'b0;
      end
      if (rx_cycle_start_rcvd || cyc_master) begin
        miss_cnt_q <= 2'h0;
      end else if (miss_step && miss_cnt_q != `LOST_ROLLS) begin
        miss_cnt_q <= miss_cnt_q + 2'h1;
      end
      // The master asks the transmitter for a start packet at each rollover
      start_req_q <= roll_pulse && cyc_master;
    end
  end

  // ----------------------------------------
  // Event flags
  // ----------------------------------------
  reg [31:0] flag_set;

  always @* begin
    flag_set                 = 32'h00000000;
    flag_set[`BIT_HDR_ERR]   = rx_hdr_crc_err;
    flag_set[`BIT_TCODE_ERR] = tx_bad_tcode;
    flag_set[`BIT_SEC_TICK]  = sec_pulse;
    flag_set[`BIT_CYC_BEGIN] = cyc_begin;
    flag_set[`BIT_CYC_DONE]  = cyc_done;
    flag_set[`BIT_CYC_PEND]  = zero_pulse || pend_q;
    flag_set[`BIT_CYC_LOST]  = cyc_lost;
    flag_set[`BIT_CARB_FAIL] = cycle_start_arb_lost;
    flag_set[`BIT_IARB_FAIL] = iso_arb_lost;
  end

  // Set wins over a clear in the same cycle, so no event is dropped
  always @* begin
    status_d = status_q;
    if (wr_clear) begin
      status_d = status_d & ~hwdata;
    end
    status_d = (status_d | flag_set) & `FLAG_IMPL_MASK;
  end

  // Irq uses the next enable word so it never lags the summary bit by a cycle
  always @* begin
    enable_d = enable_q;
    if (wr_enable) begin
      enable_d = hwdata & `FLAG_IMPL_MASK;
    end
  end

  wire summary = |(status_q & enable_q & `FLAG_IMPL_MASK);
  reg  irq_q;
  reg  pend_out_q;

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      ctrl_q     <= `RST_WORD;
      enable_q   <= `RST_WORD;
      iso_q      <= `RST_WORD;
      status_q   <= `RST_WORD;
      irq_q      <= 1'b0;
      pend_out_q <= 1'b0;
    end else begin
      status_q <= status_d;
      if (wr_ctrl) begin
        ctrl_q <= hwdata & `CTRL_IMPL_MASK;
      end
      enable_q <= enable_d;
      if (wr_iso) begin
        iso_q <= hwdata & `ISO_IMPL_MASK;
      end
      irq_q      <= |(status_d & enable_d & `FLAG_IMPL_MASK);
      pend_out_q <= zero_pulse || (pend_q && !cyc_done);
    end
  end

  // ----------------------------------------
  // Read multiplexer
  // ----------------------------------------
  reg [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h00000000;
    case (word_addr)
      `OFS_CTRL: begin
        rd_mux = ctrl_q;
      end
      `OFS_STATUS: begin
        rd_mux = status_q;
        rd_mux[`BIT_SUMMARY] = summary;
      end
      `OFS_ENABLE: begin
        rd_mux = enable_q;
      end
      `OFS_TIMER: begin
        rd_mux = timer_value;
      end
      `OFS_ISO: begin
        rd_mux = iso_q;
      end
      default: begin
        rd_mux = 32'h00000000;
      end
    endcase
  end

  // ----------------------------------------
  // Bus handshake
  // ----------------------------------------
  // Zero wait states: read data is latched at the address edge, writes land
  // one edge after the data phase opens
  always @(posedge clk) begin
    if (srst) begin
      hrdata_q    <= 32'h00000000;
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
      wr_pend_q   <= 1'b0;
      wr_addr_q   <= 12'h000;
    end else begin
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
      wr_pend_q   <= addr_phase && hwrite;
      if (addr_phase) begin
        wr_addr_q <= word_addr;
      end
      if (addr_phase && !hwrite) begin
        hrdata_q <= rd_mux;
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign hrdata          = hrdata_q;
  assign hreadyout       = hreadyout_q;
  assign hresp           = hresp_q;
  assign rx_iso_accept   = accept_w;
  assign cycle_start_req = start_req_q;
  assign cycle_pending   = pend_out_q;
  assign cycle_time      = timer_value;
  assign irq             = irq_q;

endmodule

/* File: core/cycle_timer_defines.vh */
`ifndef CYCLE_TIMER_DEFINES_VH
`define CYCLE_TIMER_DEFINES_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_CTRL        12'h008
`define OFS_STATUS      12'h00c
`define OFS_ENABLE      12'h010
`define OFS_TIMER       12'h014
`define OFS_ISO         12'h018
`define OFS_CLEAR       12'h01c

// ----------------------------------------
// Reset values and masks
// ----------------------------------------
`define RST_WORD        32'h00000000
`define FLAG_IMPL_MASK  32'h83f18000
`define ISO_IMPL_MASK   32'h0000fcfc
`define CTRL_IMPL_MASK  32'h0000001f

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_SUMMARY     0
`define BIT_HDR_ERR     15
`define BIT_TCODE_ERR   16
`define BIT_SEC_TICK    20
`define BIT_CYC_BEGIN   21
`define BIT_CYC_DONE    22
`define BIT_CYC_PEND    23
`define BIT_CYC_LOST    24
`define BIT_CARB_FAIL   25
`define BIT_IARB_FAIL   31
`define CTL_TIMER_EN    0
`define CTL_CYC_MASTER  1
`define CTL_CYC_SOURCE  2
`define CTL_ISO_A_EN    3
`define CTL_ISO_B_EN    4
`define ISO_A_CHAN_HI   7
`define ISO_A_CHAN_LO   2
`define ISO_B_CHAN_HI   15
`define ISO_B_CHAN_LO   10
`define TMR_SEC_HI      6
`define TMR_SEC_LO      0
`define TMR_CYC_HI      19
`define TMR_CYC_LO      7
`define TMR_OFS_HI      31
`define TMR_OFS_LO      20

// ----------------------------------------
// Timing counts
// ----------------------------------------
`define CLK_RATE_KHZ    19'd200000
`define OFS_RATE_KHZ    19'd24576
`define OFS_WRAP        12'd3071
`define CYC_WRAP        13'd7999
`define SEC_WRAP        7'd127
`define LOST_ROLLS      2'd2

`endif

/* File: core/bus_time_counter.v */
`include "cycle_timer_defines.vh"

module bus_time_counter (
  // Clock and reset
  input  wire        clk,
  input  wire        srst,
  // Control
  input  wire        enable,
  input  wire        ext_source,
  input  wire        ext_tick,
  input  wire        load,
  input  wire [31:0] load_value,
  // State
  output reg  [31:0] value_q,
  output reg         sec_pulse_q,
  output reg         zero_pulse_q,
  output reg         roll_pulse_q
);

  // ----------------------------------------
  // Fractional divider, 200 MHz to offset rate
  // ----------------------------------------
  localparam [18:0] STEP = `OFS_RATE_KHZ;
  localparam [18:0] MODV = `CLK_RATE_KHZ;

  reg  [18:0] acc_q;
  wire [18:0] acc_sum = acc_q + STEP;
  wire        tick    = enable && (acc_sum >= MODV);

  wire [11:0] ofs = value_q[`TMR_OFS_HI:`TMR_OFS_LO];
  wire [12:0] cyc = value_q[`TMR_CYC_HI:`TMR_CYC_LO];
  wire [6:0]  sec = value_q[`TMR_SEC_HI:`TMR_SEC_LO];

  // External source replaces the internal wrap; offset then holds at the top
  wire wrap    = enable && (ext_source ? ext_tick : (tick && ofs == `OFS_WRAP));
  wire cyc_end = wrap && (cyc == `CYC_WRAP);

  always @(posedge clk) begin
    if (srst) begin
      acc_q        <= 19'h00000;
      value_q      <= `RST_WORD;
      sec_pulse_q  <= 1'b0;
      zero_pulse_q <= 1'b0;
      roll_pulse_q <= 1'b0;
    end else begin
      acc_q        <= enable ? (tick ? acc_sum - MODV : acc_sum) : acc_q;
      sec_pulse_q  <= 1'b0;
      roll_pulse_q <= 1'b0;
      zero_pulse_q <= 1'b0;
      if (load) begin
        value_q      <= load_value;
        zero_pulse_q <= (load_value[`TMR_OFS_HI:`TMR_OFS_LO] == 12'h000);
      end else if (wrap) begin
        value_q[`TMR_OFS_HI:`TMR_OFS_LO] <= 12'h000;
        value_q[`TMR_CYC_HI:`TMR_CYC_LO] <= cyc_end ? 13'h0000 : cyc + 13'h0001;
        if (cyc_end) begin
          value_q[`TMR_SEC_HI:`TMR_SEC_LO] <= (sec == `SEC_WRAP) ? 7'h00 : sec + 7'h01;
        end
        sec_pulse_q  <= cyc_end;
        roll_pulse_q <= 1'b1;
        zero_pulse_q <= 1'b1;
      end else if (tick && ofs != `OFS_WRAP) begin
        value_q[`TMR_OFS_HI:`TMR_OFS_LO] <= ofs + 12'h001;
      end
    end
  end

endmodule

/* File: core/iso_channel_match.v */
`include "cycle_timer_defines.vh"

module iso_channel_match (
  // Clock and reset
  input  wire       clk,
  input  wire       srst,
  // Channel selection
  input  wire [1:0] port_enable,
  input  wire [5:0] chan_a,
  input  wire [5:0] chan_b,
  // Incoming header
  input  wire       hdr_valid,
  input  wire [5:0] hdr_channel,
  // Verdict
  output reg        accept_q
);

  wire [11:0] chans = {chan_b, chan_a};
  wire [1:0]  hit;

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_port
      assign hit[i] = port_enable[i] && (hdr_channel == chans[i*6 +: 6]);
    end
  endgenerate

  always @(posedge clk) begin
    if (srst) begin
      accept_q <= 1'b0;
    end else begin
      accept_q <= hdr_valid && (|hit);
    end
  end

endmodule

/* File: dv/event_flag_regs_asserts.sv */
`include "cycle_timer_defines.vh"

module event_flag_regs_asserts (
  // Clock and reset
  input wire        clk,
  input wire        srst,
  // Register bus
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  // Events and outputs
  input wire        arb_gap_seen,
  input wire        rx_iso_hdr_valid,
  input wire        rx_iso_accept,
  input wire        cycle_pending,
  input wire [31:0] cycle_time,
  input wire        irq
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  wire       rd_take = hsel && htrans[1] && hready && !hwrite;
  wire [9:0] idx     = haddr[11:2];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  reset_quiet_a: assert property (disable iff (1'b0)
    srst |=> !irq && !cycle_pending && hrdata == 32'h0 && cycle_time == 32'h0)
    else $error("outputs not cleared by reset");
  timer_read_a: assert property (rd_take && idx == 10'h005 |=>
    hrdata == $past(cycle_time))
    else $error("timer read differs from timer value");
  iso_rsvd_a: assert property (rd_take && idx == 10'h006 |=>
    (hrdata & ~`ISO_IMPL_MASK) == 32'h0)
    else $error("channel register reserved bits set");
  flag_rsvd_a: assert property (rd_take && idx == 10'h003 |=>
    (hrdata & ~(`FLAG_IMPL_MASK | 32'h1)) == 32'h0)
    else $error("status reserved bits set");
  summary_bit_a: assert property (rd_take && idx == 10'h003 |=>
    hrdata[0] == $past(irq))
    else $error("summary bit disagrees with irq");
  unmapped_zero_a: assert property (rd_take && (idx < 10'h002 || idx > 10'h006) |=>
    hrdata == 32'h0)
    else $error("unmapped read not zero");
  accept_cause_a: assert property (rx_iso_accept |-> $past(rx_iso_hdr_valid))
    else $error("accept without header");
  pend_end_a: assert property ($fell(cycle_pending) |-> $past(arb_gap_seen))
    else $error("pending dropped without gap");

  cover property (rx_iso_accept);
  cover property ($fell(cycle_pending));
  cover property ($rose(irq));
endmodule

bind event_flag_regs event_flag_regs_asserts u_chk (
  .clk, .srst, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp,
  .arb_gap_seen, .rx_iso_hdr_valid, .rx_iso_accept, .cycle_pending, .cycle_time, .irq
);

/* File: dv/link_side_model.sv */
module link_side_model (
  // Clock
  input  wire        clk,
  // Events and iso header towards the block
  output logic [6:0] ev,
  output logic       hdr_valid,
  output logic [5:0] hdr_chan
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    ev = 7'h00;
    hdr_valid = 1'b0;
    hdr_chan = 6'h2a;
  end

  // One-cycle strobe: a held level would set the flag again every cycle
  // An idle edge follows, so two calls never assign ev in one time step
  task pulse(input int n);
    ev <= 7'h01 << n;
    @(posedge clk);
    ev <= 7'h00;
    @(posedge clk);
  endtask

  // Released channel lines show the inverse, never the last value
  task header(input logic [5:0] ch);
    hdr_valid <= 1'b1;
    hdr_chan <= ch;
    @(posedge clk);
    hdr_valid <= 1'b0;
    hdr_chan <= ~ch;
  endtask
endmodule

/* File: dv/cycle_timer_event_flags_tb_top.sv */
`include "cycle_timer_defines.vh"

module cycle_timer_event_flags_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [31:0] a_ctl = `OFS_CTRL;
  localparam logic [31:0] a_st  = `OFS_STATUS;
  localparam logic [31:0] a_en  = `OFS_ENABLE;
  localparam logic [31:0] a_tmr = `OFS_TIMER;
  localparam logic [31:0] a_iso = `OFS_ISO;
  localparam logic [31:0] a_clr = `OFS_CLEAR;

  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        ext_pin = 1'b0;
  wire  [31:0] hrdata, cycle_time;
  wire  [6:0]  ev;
  wire  [5:0]  hc;
  wire         hreadyout, hresp, hv, rx_iso_accept, cycle_start_req, cycle_pending, irq;
  int          failures = 0;
  int          n_compared = 0;
  int          exp_st = 0;
  int          exp_en = 0;
  int          n_req = 0;
  int          ev_idx[8] = '{6, 0, 1, 2, 3, 4, 5, 6};
  int          ev_bit[8] = '{-1, 15, 21, 16, 21, 25, 31, 22};

  always #2.5 clk = ~clk;
  always @(posedge clk) if (cycle_start_req === 1'b1) n_req++;

  link_side_model lnk (.clk(clk), .ev(ev), .hdr_valid(hv), .hdr_chan(hc));

  event_flag_regs u_dut (
    .clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rx_hdr_crc_err(ev[0]), .rx_cycle_start_rcvd(ev[1]),
    .tx_bad_tcode(ev[2]), .tx_cycle_start_sent(ev[3]), .cycle_start_arb_lost(ev[4]),
    .iso_arb_lost(ev[5]), .arb_gap_seen(ev[6]), .ext_cycle_pin(ext_pin),
    .rx_iso_hdr_valid(hv), .rx_iso_channel(hc), .rx_iso_accept(rx_iso_accept),
    .cycle_start_req(cycle_start_req), .cycle_pending(cycle_pending),
    .cycle_time(cycle_time), .irq(irq)
  );

  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic end_sim();
    if (failures == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    r = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] r);
    xfer(1'b0, a, 32'h0, r);
  endtask

  task automatic rdc(input string what, input logic [31:0] a, e);
    logic [31:0] v;
    rd(a, v);
    chk(what, e, v);
  endtask

  task automatic st_check();
    logic [31:0] e;
    e = exp_st;
    e[0] = (exp_st & exp_en) != 0;
    rdc("status", a_st, e);
    chk("irq", {31'h0, e[0]}, {31'h0, irq});
  endtask

  task automatic ev_case(input int n, input int b);
    lnk.pulse(n);
    if (b >= 0) exp_st |= 1 << b;
    st_check();
    wr(a_clr, exp_st);
    exp_st = 0;
    st_check();
  endtask

  task automatic iso_case(input logic [5:0] c, input logic [31:0] iso, input int en);
    logic e;
    e = (en[0] && c == iso[7:2]) || (en[1] && c == iso[15:10]);
    lnk.header(c);
    @(negedge clk);
    chk("accept", {31'h0, e}, {31'h0, rx_iso_accept});
    @(posedge clk);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] v;
    logic [31:0] iso;
    int n;
    v = $urandom(32'h7dea0aa0);
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    for (int a = 8; a <= 64; a += 4) rdc("reset", a, 0);
    iso = $urandom;
    wr(a_iso, iso);
    iso &= `ISO_IMPL_MASK;
    rdc("iso", a_iso, iso);
    for (int en = 0; en < 4; en++) begin
      wr(a_ctl, en << 3);
      iso_case(iso[7:2], iso, en);
      iso_case(iso[15:10], iso, en);
      iso_case(6'($urandom), iso, en);
    end
    wr(a_ctl, 0);
    for (int m = 0; m < 2; m++) begin
      exp_en = m ? 0 : `FLAG_IMPL_MASK;
      wr(a_en, exp_en);
      rdc("enable", a_en, exp_en);
      for (int i = 0; i < 8; i++) ev_case(ev_idx[i], ev_bit[i]);
    end
    wr(a_tmr, {12'd3071, 13'd7999, 7'd127});
    rdc("timer", a_tmr, {12'd3071, 13'd7999, 7'd127});
    n_req = 0;
    wr(a_ctl, 32'h3);
    // Offset moves about once per 8 clocks, so 20 clocks cross the wrap
    repeat (20) @(posedge clk);
    rd(a_tmr, v);
    chk("timer low", 0, v[19:0]);
    chk("offset small", 1, {31'h0, v[31:20] < 12'd6});
    chk("start req", 1, n_req);
    chk("pending", 1, {31'h0, cycle_pending});
    exp_st = 32'h00900000;
    st_check();
    wr(a_clr, 32'h00800000);
    st_check();
    lnk.pulse(3);
    lnk.pulse(6);
    exp_st = 32'h00f00000;
    st_check();
    chk("pending", 0, {31'h0, cycle_pending});
    wr(a_clr, 32'hffffffff);
    exp_st = 0;
    exp_en = `FLAG_IMPL_MASK;
    wr(a_en, exp_en);
    wr(a_ctl, 32'h1);
    wr(a_tmr, {12'd3071, 20'h0});
    n_req = 0;
    n = 0;
    while (cycle_time[19:7] !== 13'd2 && n < 30000) begin
      @(posedge clk);
      n++;
    end
    repeat (4) @(posedge clk);
    exp_st = 32'h01800000;
    st_check();
    chk("start req", 0, n_req);
    // External source: only a pin rise advances the cycle count
    wr(a_ctl, 32'h5);
    v = cycle_time;
    ext_pin <= 1'b1;
    repeat (8) @(posedge clk);
    chk("ext wrap", {19'h0, v[19:7] + 13'd1}, {19'h0, cycle_time[19:7]});
    end_sim();
  end

  initial begin
    #300000;
    failures++;
    end_sim();
  end
endmodule
